//--- hw/mvd_regs.sv
// mvd_regs: control register bank of a memory-mapped virtual i/o device.
// assumes one clock; the driver side issues single-cycle read or write
// strobes in this clock domain, 32-bit aligned for control registers.
//
// Overview of operation
// - device feature select picks 32-bit feature word
// - driver feature write stores word at select*32
// - driver feature select picks word to update
// - queue select steers per-queue registers, base zero
// - size limit read, zero for absent queue
// - queue size write stored per queue
// - enable write of one enables queue
// - enable reads back last value, per queue
// - doorbell write requests processing of queue
// - pending bit 0 marks used ring update
// - pending bit 1 marks configuration change
// - clear mask write clears handled events
// - status reads flags, nonzero write sets them
// - status write of zero resets device
// - descriptor table address, 64 bits, lo/hi
// - available ring address, 64 bits, lo/hi
// - used ring address, 64 bits, lo/hi
// - generation stable unless configuration changed
// - config space at 0x100, byte accessible
// - registers little-endian on the bus
// - pending bits sticky until cleared
// - reset clears pending bits and enables
// - one interrupt output while any pending
`timescale 1ns/1ps
module mvd_regs #(
    parameter int NUM_QUEUES = 8,
    parameter int QSIZE_MAX  = 256,
    parameter int FEAT_WORDS = 2,
    parameter int CFG_BYTES  = 64
) (
    // clock and reset
    input  wire logic                         i_mclk,
    input  wire logic                         i_reset,
    // driver register access
    input  wire logic                         i_wr,
    input  wire logic                         i_rd,
    input  wire logic [11:0]                  i_addr,
    input  wire logic [31:0]                  i_wdata,
    input  wire logic [3:0]                   i_be,
    output logic      [31:0]                  o_rdata,
    output logic                              o_rack,
    // device-side events and config updates
    input  wire logic                         i_used_event,
    input  wire logic                         i_cfg_change,
    input  wire logic                         i_dcfg_we,
    input  wire logic [11:0]                  i_dcfg_addr,
    input  wire logic [7:0]                   i_dcfg_data,
    // device-side queue lookup
    input  wire logic [31:0]                  i_q_look,
    output logic      [31:0]                  o_q_size,
    output logic      [63:0]                  o_q_desc,
    output logic      [63:0]                  o_q_avail,
    output logic      [63:0]                  o_q_used,
    // state towards the device core
    output logic      [NUM_QUEUES-1:0]        o_queue_enable,
    output logic      [31:0]                  o_dev_feat_sel,
    output logic      [FEAT_WORDS*32-1:0]     o_drv_features,
    output logic      [31:0]                  o_dev_status,
    output logic                              o_dev_reset,
    output logic                              o_doorbell,
    output logic      [31:0]                  o_doorbell_index,
    output logic                              o_irq
);
    ////////////////////////////////////////////////////////////////////////////
    // storage
    logic [31:0]            q_size_q  [NUM_QUEUES];
    logic [63:0]            q_desc_q  [NUM_QUEUES];
    logic [63:0]            q_avail_q [NUM_QUEUES];
    logic [63:0]            q_used_q  [NUM_QUEUES];
    logic [NUM_QUEUES-1:0]  q_en_q;
    logic [31:0]            feat_q    [FEAT_WORDS];
    logic [7:0]             cfg_q     [CFG_BYTES];
    logic [31:0]            qsel_q;
    logic [31:0]            dsel_q;
    logic [31:0]            fsel_q;
    logic [31:0]            status_q;
    logic [31:0]            gen_q;
    logic [1:0]             evt_q;
    logic [1:0]             evt_d;
    logic [31:0]            rdata_d;

    ////////////////////////////////////////////////////////////////////////////
    // address decode
    wire        w_ctl      = (i_addr < mvd_pkg::OFS_CFG_SPACE);
    wire        w_hit_feat = i_wr && (i_addr == mvd_pkg::OFS_DRV_FEAT);
    wire        w_hit_stat = i_wr && (i_addr == mvd_pkg::OFS_DEV_STATUS);
    wire        w_soft_rst = w_hit_stat && (i_wdata == mvd_pkg::RST_WORD);
    wire        w_qvalid   = (qsel_q < 32'(NUM_QUEUES));
    wire [31:0] w_qi       = w_qvalid ? qsel_q : 32'h0000_0000;
    wire        w_qwr      = i_wr && w_qvalid;
    wire        w_fvalid   = (fsel_q < 32'(FEAT_WORDS));
    wire [11:0] w_cfg_off  = i_addr - mvd_pkg::OFS_CFG_SPACE;
    wire [1:0]  w_clr      = (i_wr && i_addr == mvd_pkg::OFS_EVT_CLEAR) ?
                             i_wdata[1:0] : 2'h0;
    wire [1:0]  w_set      = {i_cfg_change, i_used_event};
    wire        w_lvalid   = (i_q_look < 32'(NUM_QUEUES));
    wire [31:0] w_li       = w_lvalid ? i_q_look : 32'h0000_0000;

    // pending events: set beats clear; soft reset clears all
    always_comb
    begin
        evt_d = (evt_q & ~w_clr) | w_set;
        if (w_soft_rst)
        begin
            evt_d = mvd_pkg::RST_EVT;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data mux, little-endian byte lanes for config space
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        if (w_ctl)
        begin
            case (i_addr)
                mvd_pkg::OFS_QUEUE_LIMIT:
                    rdata_d = w_qvalid ? 32'(QSIZE_MAX) : 32'h0000_0000;
                mvd_pkg::OFS_QUEUE_ENABLE:
                    rdata_d = {31'h0, w_qvalid & q_en_q[w_qi]};
                mvd_pkg::OFS_EVT_PENDING:
                    rdata_d = {30'h0, evt_q};
                mvd_pkg::OFS_DEV_STATUS:
                    rdata_d = status_q;
                mvd_pkg::OFS_CFG_GEN:
                    rdata_d = gen_q;
                default:
                    rdata_d = 32'h0000_0000;
            endcase
        end
        else
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (32'(w_cfg_off) + 32'(b) < 32'(CFG_BYTES) && i_be[b])
                begin
                    rdata_d[8*b +: 8] = cfg_q[32'(w_cfg_off) + 32'(b)];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read answer one cycle after the strobe
    always_ff @(posedge i_mclk or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_rdata <= 32'h0000_0000;
            o_rack  <= 1'b0;
        end
        else
        begin
            o_rack  <= i_rd;
            o_rdata <= i_rd ? rdata_d : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // selects, status, events, interrupt, doorbell
    always_ff @(posedge i_mclk or posedge i_reset)
    begin
        if (i_reset)
        begin
            qsel_q           <= mvd_pkg::RST_WORD;
            dsel_q           <= mvd_pkg::RST_WORD;
            fsel_q           <= mvd_pkg::RST_WORD;
            status_q         <= mvd_pkg::RST_WORD;
            evt_q            <= mvd_pkg::RST_EVT;
            o_irq            <= 1'b0;
            o_dev_reset      <= 1'b0;
            o_doorbell       <= 1'b0;
            o_doorbell_index <= 32'h0000_0000;
        end
        else
        begin
            evt_q       <= evt_d;
            o_irq       <= |evt_d;
            o_dev_reset <= w_soft_rst;
            o_doorbell  <= i_wr && i_addr == mvd_pkg::OFS_DOORBELL;
            if (i_wr && i_addr == mvd_pkg::OFS_DOORBELL)
            begin
                o_doorbell_index <= i_wdata;
            end
            if (w_soft_rst)
            begin
                qsel_q   <= mvd_pkg::RST_WORD;
                dsel_q   <= mvd_pkg::RST_WORD;
                fsel_q   <= mvd_pkg::RST_WORD;
                status_q <= mvd_pkg::RST_WORD;
            end
            else
            begin
                if (w_hit_stat)
                begin
                    status_q <= i_wdata;
                end
                if (i_wr && i_addr == mvd_pkg::OFS_QUEUE_SEL)
                begin
                    qsel_q <= i_wdata;
                end
                if (i_wr && i_addr == mvd_pkg::OFS_DEV_FEAT_SEL)
                begin
                    dsel_q <= i_wdata;
                end
                if (i_wr && i_addr == mvd_pkg::OFS_DRV_FEAT_SEL)
                begin
                    fsel_q <= i_wdata;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // generation counter: bumps on a config change event or a device-side config byte write
    always_ff @(posedge i_mclk or posedge i_reset)
    begin
        if (i_reset)
        begin
            gen_q <= mvd_pkg::RST_WORD;
        end
        else if (i_cfg_change || i_dcfg_we)
        begin
            gen_q <= gen_q + 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-queue state, one generate slice per queue
    genvar gq;
    generate
        for (gq = 0; gq < NUM_QUEUES; gq++)
        begin : g_queue
            wire w_me = w_qwr && (qsel_q == 32'(gq));
            always_ff @(posedge i_mclk or posedge i_reset)
            begin
                if (i_reset)
                begin
                    q_en_q[gq]    <= 1'b0;
                    q_size_q[gq]  <= mvd_pkg::RST_WORD;
                    q_desc_q[gq]  <= 64'h0;
                    q_avail_q[gq] <= 64'h0;
                    q_used_q[gq]  <= 64'h0;
                end
                else if (w_soft_rst)
                begin
                    q_en_q[gq]    <= 1'b0;
                    q_size_q[gq]  <= mvd_pkg::RST_WORD;
                    q_desc_q[gq]  <= 64'h0;
                    q_avail_q[gq] <= 64'h0;
                    q_used_q[gq]  <= 64'h0;
                end
                else if (w_me)
                begin
                    case (i_addr)
                        mvd_pkg::OFS_QUEUE_ENABLE: q_en_q[gq] <= i_wdata[0];
                        mvd_pkg::OFS_QUEUE_SIZE:   q_size_q[gq] <= i_wdata;
                        mvd_pkg::OFS_DESC_LO:  q_desc_q[gq][31:0]   <= i_wdata;
                        mvd_pkg::OFS_DESC_HI:  q_desc_q[gq][63:32]  <= i_wdata;
                        mvd_pkg::OFS_AVAIL_LO: q_avail_q[gq][31:0]  <= i_wdata;
                        mvd_pkg::OFS_AVAIL_HI: q_avail_q[gq][63:32] <= i_wdata;
                        mvd_pkg::OFS_USED_LO:  q_used_q[gq][31:0]   <= i_wdata;
                        mvd_pkg::OFS_USED_HI:  q_used_q[gq][63:32]  <= i_wdata;
                        default:               q_en_q[gq] <= q_en_q[gq];
                    endcase
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // activated feature words
    genvar gf;
    generate
        for (gf = 0; gf < FEAT_WORDS; gf++)
        begin : g_feat
            always_ff @(posedge i_mclk or posedge i_reset)
            begin
                if (i_reset)
                begin
                    feat_q[gf] <= mvd_pkg::RST_WORD;
                end
                else if (w_soft_rst)
                begin
                    feat_q[gf] <= mvd_pkg::RST_WORD;
                end
                else if (w_hit_feat && w_fvalid && fsel_q == 32'(gf))
                begin
                    feat_q[gf] <= i_wdata;
                end
            end
            assign o_drv_features[gf*32 +: 32] = feat_q[gf];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // config bytes: device-side update wins over a driver write
    genvar gc;
    generate
        for (gc = 0; gc < CFG_BYTES; gc++)
        begin : g_cfg
            wire [11:0] w_rel = 12'(gc);
            always_ff @(posedge i_mclk or posedge i_reset)
            begin
                if (i_reset)
                begin
                    cfg_q[gc] <= 8'h00;
                end
                else if (i_dcfg_we && i_dcfg_addr == w_rel)
                begin
                    cfg_q[gc] <= i_dcfg_data;
                end
                else if (i_wr && !w_ctl && (w_rel - w_cfg_off) < 12'h004
                         && w_rel >= w_cfg_off && i_be[2'(w_rel - w_cfg_off)])
                begin
                    cfg_q[gc] <= i_wdata[8*(w_rel - w_cfg_off) +: 8];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // device-side lookup port, registered
    always_ff @(posedge i_mclk or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_q_size  <= 32'h0000_0000;
            o_q_desc  <= 64'h0;
            o_q_avail <= 64'h0;
            o_q_used  <= 64'h0;
        end
        else
        begin
            o_q_size  <= w_lvalid ? q_size_q[w_li]  : 32'h0000_0000;
            o_q_desc  <= w_lvalid ? q_desc_q[w_li]  : 64'h0;
            o_q_avail <= w_lvalid ? q_avail_q[w_li] : 64'h0;
            o_q_used  <= w_lvalid ? q_used_q[w_li]  : 64'h0;
        end
    end

    assign o_queue_enable = q_en_q;
    assign o_dev_feat_sel = dsel_q;
    assign o_dev_status   = status_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    AST_SEL_FEAT: assert property (@(posedge i_mclk) disable iff (i_reset)
        (i_wr && i_addr == mvd_pkg::OFS_DEV_FEAT_SEL) |=> o_dev_feat_sel == $past(i_wdata))
        else $error("device feature select not stored");
    AST_EVT_SET: assert property (@(posedge i_mclk) disable iff (i_reset)
        (i_used_event && !w_soft_rst) |=> evt_q[mvd_pkg::EVT_USED_BIT] && o_irq)
        else $error("used ring event lost");
    AST_CFG_SET: assert property (@(posedge i_mclk) disable iff (i_reset)
        (i_cfg_change && !w_soft_rst) |=> evt_q[mvd_pkg::EVT_CFG_BIT] && gen_q != $past(gen_q))
        else $error("config change not flagged");
    AST_STICKY: assert property (@(posedge i_mclk) disable iff (i_reset)
        (evt_q[0] && !w_clr[0] && !w_soft_rst) |=> evt_q[0])
        else $error("pending bit dropped without clear");
    AST_ACK: assert property (@(posedge i_mclk) disable iff (i_reset)
        (w_clr[1] && !i_cfg_change) |=> !evt_q[1])
        else $error("clear mask ignored");
    AST_IRQ: assert property (@(posedge i_mclk) disable iff (i_reset)
        o_irq == (|evt_q))
        else $error("interrupt does not follow pending bits");
    AST_SOFT_RST: assert property (@(posedge i_mclk) disable iff (i_reset)
        w_soft_rst |=> o_dev_reset && o_queue_enable == '0 && o_dev_status == 32'h0)
        else $error("zero status write did not reset");
    AST_GEN_STABLE: assert property (@(posedge i_mclk) disable iff (i_reset)
        (!i_cfg_change && !i_dcfg_we) |=> $stable(gen_q))
        else $error("generation moved without change");
    AST_DOORBELL: assert property (@(posedge i_mclk) disable iff (i_reset)
        (i_wr && i_addr == mvd_pkg::OFS_DOORBELL)
        |=> o_doorbell && o_doorbell_index == $past(i_wdata))
        else $error("doorbell pulse wrong");
    AST_RACK: assert property (@(posedge i_mclk) disable iff (i_reset)
        (i_rd && i_addr == mvd_pkg::OFS_QUEUE_SEL) |=> o_rack && o_rdata == 32'h0)
        else $error("unmapped read not zero");
endmodule : mvd_regs

//--- inc/mvd_pkg.sv
// mvd_pkg: offsets, field positions and reset values of the mmio register bank.
// assumes byte addresses on a 12-bit window and 32-bit data words.
package mvd_pkg;
    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [11:0] OFS_DEV_FEAT_SEL  = 12'h014;
    localparam logic [11:0] OFS_DRV_FEAT      = 12'h020;
    localparam logic [11:0] OFS_DRV_FEAT_SEL  = 12'h024;
    localparam logic [11:0] OFS_QUEUE_SEL     = 12'h030;
    localparam logic [11:0] OFS_QUEUE_LIMIT   = 12'h034;
    localparam logic [11:0] OFS_QUEUE_SIZE    = 12'h038;
    localparam logic [11:0] OFS_QUEUE_ENABLE  = 12'h044;
    localparam logic [11:0] OFS_DOORBELL      = 12'h050;
    localparam logic [11:0] OFS_EVT_PENDING   = 12'h060;
    localparam logic [11:0] OFS_EVT_CLEAR     = 12'h064;
    localparam logic [11:0] OFS_DEV_STATUS    = 12'h070;
    localparam logic [11:0] OFS_DESC_LO       = 12'h080;
    localparam logic [11:0] OFS_DESC_HI       = 12'h084;
    localparam logic [11:0] OFS_AVAIL_LO      = 12'h090;
    localparam logic [11:0] OFS_AVAIL_HI      = 12'h094;
    localparam logic [11:0] OFS_USED_LO       = 12'h0A0;
    localparam logic [11:0] OFS_USED_HI       = 12'h0A4;
    localparam logic [11:0] OFS_CFG_GEN       = 12'h0FC;
    localparam logic [11:0] OFS_CFG_SPACE     = 12'h100;
    ////////////////////////////////////////////////////////////////////////////
    // event mask fields and widths
    localparam int          EVT_USED_BIT      = 0;
    localparam int          EVT_CFG_BIT       = 1;
    localparam int          EVT_W             = 2;
    localparam int          WORD_W            = 32;
    localparam int          FEAT_WORD_BITS    = 32;
    // reset values
    localparam logic [31:0] RST_WORD          = 32'h0000_0000;
    localparam logic [1:0]  RST_EVT           = 2'h0;
endpackage : mvd_pkg

//--- bench/mvd_drv_model.sv
// mvd_drv_model: guest driver side of the register bank, single-cycle strobes.
// assumes the bank samples its strobes on the rising edge of i_mclk.
`timescale 1ns/1ps
module mvd_drv_model (
    // clock
    input  wire logic        i_mclk,
    // register access towards the bank
    output logic             o_wr,
    output logic             o_rd,
    output logic [11:0]      o_addr,
    output logic [31:0]      o_wdata,
    output logic [3:0]       o_be,
    input  wire logic [31:0] i_rdata,
    input  wire logic        i_rack
);
    ////////////////////////////////////////////////////////////////////////////
    // idle bus from time zero
    initial
    begin
        o_wr    = 1'b0;
        o_rd    = 1'b0;
        o_addr  = 12'h000;
        o_wdata = 32'h0000_0000;
        o_be    = 4'hF;
    end
    // one write, raised and dropped at falling edges around one rising edge
    task automatic wr(input logic [11:0] addr, input logic [31:0] data, input logic [3:0] be);
        @(negedge i_mclk);
        o_wr    = 1'b1;
        o_addr  = addr;
        o_wdata = data;  // doorbell index or clear mask as given
        o_be    = be;
        @(negedge i_mclk);
        o_wr    = 1'b0;
        o_wdata = ~data; // released data shows no stale value
    endtask : wr
    // one read; data is unknown unless the acknowledge came in time
    task automatic rd(input logic [11:0] addr, output logic [31:0] data);
        @(negedge i_mclk);
        o_rd   = 1'b1;
        o_addr = addr;
        o_be   = 4'hF; // whole word, so config reads see every lane
        @(negedge i_mclk);
        o_rd   = 1'b0;
        o_addr = ~addr;
        data   = (i_rack === 1'b1) ? i_rdata : 32'hXXXX_XXXX;
    endtask : rd
endmodule : mvd_drv_model

//--- bench/tb_mvd_regs.sv
// tb_mvd_regs: self-checking bench of the register bank through the driver model.
// assumes the default queue, feature and config parameters of the bank.
`timescale 1ns/1ps
module tb_mvd_regs;
    logic        i_mclk;
    logic        i_reset;
    logic        i_wr;
    logic        i_rd;
    logic [11:0] i_addr;
    logic [31:0] i_wdata;
    logic [3:0]  i_be;
    logic [31:0] o_rdata;
    logic        o_rack;
    logic        i_used_event;
    logic        i_cfg_change;
    logic        i_dcfg_we;
    logic [11:0] i_dcfg_addr;
    logic [7:0]  i_dcfg_data;
    logic [31:0] i_q_look;
    logic [31:0] o_q_size;
    logic [63:0] o_q_desc;
    logic [63:0] o_q_avail;
    logic [63:0] o_q_used;
    logic [7:0]  o_queue_enable;
    logic [31:0] o_dev_feat_sel;
    logic [63:0] o_drv_features;
    logic [31:0] o_dev_status;
    logic        o_dev_reset;
    logic        o_doorbell;
    logic [31:0] o_doorbell_index;
    logic        o_irq;
    logic [31:0] g0;
    logic [31:0] v;
    int          err_count = 0;
    int          n_compared = 0;
    int          cyc = 0;
    ////////////////////////////////////////////////////////////////////////////
    // clock, driver model and bank
    initial
    begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end
    mvd_drv_model u_drv (.i_mclk(i_mclk), .o_wr(i_wr), .o_rd(i_rd), .o_addr(i_addr),
        .o_wdata(i_wdata), .o_be(i_be), .i_rdata(o_rdata), .i_rack(o_rack));
    mvd_regs DUT (.i_mclk(i_mclk), .i_reset(i_reset), .i_wr(i_wr), .i_rd(i_rd),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_be(i_be), .o_rdata(o_rdata),
        .o_rack(o_rack), .i_used_event(i_used_event), .i_cfg_change(i_cfg_change),
        .i_dcfg_we(i_dcfg_we), .i_dcfg_addr(i_dcfg_addr), .i_dcfg_data(i_dcfg_data),
        .i_q_look(i_q_look), .o_q_size(o_q_size), .o_q_desc(o_q_desc),
        .o_q_avail(o_q_avail), .o_q_used(o_q_used), .o_queue_enable(o_queue_enable),
        .o_dev_feat_sel(o_dev_feat_sel), .o_drv_features(o_drv_features),
        .o_dev_status(o_dev_status), .o_dev_reset(o_dev_reset), .o_doorbell(o_doorbell),
        .o_doorbell_index(o_doorbell_index), .o_irq(o_irq));
    ////////////////////////////////////////////////////////////////////////////
    // compare, read-compare, device-side pulses and closing report
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        u_drv.rd(a, d);
        chk({32'h0, d}, {32'h0, exp}, what);
    endtask : rchk
    task automatic pulse_evt(input logic used, input logic cfg);
        @(negedge i_mclk);
        i_used_event = used;
        i_cfg_change = cfg;
        @(negedge i_mclk);
        i_used_event = 1'b0;
        i_cfg_change = 1'b0;
    endtask : pulse_evt
    task automatic wrap_up;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    // hang guard, far above the hundred or so cycles the tests need
    always @(posedge i_mclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_count++;
            $display("mismatch at %0t: run did not finish", $time);
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        i_reset = 1'b1;
        i_used_event = 1'b0;
        i_cfg_change = 1'b0;
        i_dcfg_we = 1'b0;
        i_dcfg_addr = 12'h000;
        i_dcfg_data = 8'h00;
        i_q_look = 32'h0000_0003;
        repeat (5) @(negedge i_mclk);
        i_reset = 1'b0;
        rchk(mvd_pkg::OFS_EVT_PENDING, 32'h0, "pending after reset");
        rchk(mvd_pkg::OFS_QUEUE_ENABLE, 32'h0, "enable after reset");
        $display("test reset done");
        // per-queue state steered by the select, then seen on the lookup
        u_drv.wr(mvd_pkg::OFS_QUEUE_SEL, 32'h3, 4'hF);
        u_drv.wr(mvd_pkg::OFS_QUEUE_SIZE, 32'h10, 4'hF);
        u_drv.wr(mvd_pkg::OFS_DESC_LO, 32'h1111_0000, 4'hF);
        u_drv.wr(mvd_pkg::OFS_DESC_HI, 32'h0000_2222, 4'hF);
        u_drv.wr(mvd_pkg::OFS_AVAIL_LO, 32'h3333_0000, 4'hF);
        u_drv.wr(mvd_pkg::OFS_AVAIL_HI, 32'h0000_4444, 4'hF);
        u_drv.wr(mvd_pkg::OFS_USED_LO, 32'h5555_0000, 4'hF);
        u_drv.wr(mvd_pkg::OFS_USED_HI, 32'h0000_6666, 4'hF);
        u_drv.wr(mvd_pkg::OFS_QUEUE_ENABLE, 32'h1, 4'hF);
        rchk(mvd_pkg::OFS_QUEUE_LIMIT, 32'h100, "limit of queue 3");
        chk({32'h0, o_q_size}, 64'h10, "size of queue 3");
        chk(o_q_desc, 64'h0000_2222_1111_0000, "desc addr");
        chk(o_q_avail, 64'h0000_4444_3333_0000, "avail addr");
        chk(o_q_used, 64'h0000_6666_5555_0000, "used addr");
        chk({56'h0, o_queue_enable}, 64'h08, "enable bits");
        u_drv.wr(mvd_pkg::OFS_QUEUE_SEL, 32'h0, 4'hF);
        rchk(mvd_pkg::OFS_QUEUE_ENABLE, 32'h0, "enable of queue 0");
        u_drv.wr(mvd_pkg::OFS_QUEUE_SEL, 32'h9, 4'hF);
        rchk(mvd_pkg::OFS_QUEUE_LIMIT, 32'h0, "limit of absent queue");
        u_drv.wr(mvd_pkg::OFS_QUEUE_SEL, 32'h3, 4'hF);
        rchk(mvd_pkg::OFS_QUEUE_ENABLE, 32'h1, "enable of queue 3");
        $display("test queues done");
        // feature words, the doorbell and unmapped places
        u_drv.wr(mvd_pkg::OFS_DEV_FEAT_SEL, 32'h1, 4'hF);
        chk({32'h0, o_dev_feat_sel}, 64'h1, "device feature select");
        u_drv.wr(mvd_pkg::OFS_DRV_FEAT_SEL, 32'h1, 4'hF);
        u_drv.wr(mvd_pkg::OFS_DRV_FEAT, 32'hA5C3_0F81, 4'hF);
        chk(o_drv_features, 64'hA5C3_0F81_0000_0000, "driver features");
        u_drv.wr(mvd_pkg::OFS_DOORBELL, 32'h5, 4'hF);
        chk({31'h0, o_doorbell, o_doorbell_index}, {31'h0, 1'b1, 32'h5}, "doorbell");
        u_drv.wr(mvd_pkg::OFS_QUEUE_LIMIT, 32'h7, 4'hF);
        rchk(mvd_pkg::OFS_QUEUE_LIMIT, 32'h100, "limit after write");
        rchk(mvd_pkg::OFS_QUEUE_SEL, 32'h0, "write-only read");
        rchk(12'h0F0, 32'h0, "unmapped read");
        $display("test features done");
        // events stay until acknowledged, generation moves on change
        u_drv.rd(mvd_pkg::OFS_CFG_GEN, g0);
        rchk(mvd_pkg::OFS_CFG_GEN, g0, "generation unchanged");
        pulse_evt(1'b1, 1'b0);
        rchk(mvd_pkg::OFS_EVT_PENDING, 32'h1, "used event");
        chk({63'h0, o_irq}, 64'h1, "irq on used event");
        pulse_evt(1'b0, 1'b1);
        rchk(mvd_pkg::OFS_EVT_PENDING, 32'h3, "config event");
        rchk(mvd_pkg::OFS_CFG_GEN, g0 + 32'h1, "generation after change");
        u_drv.wr(mvd_pkg::OFS_EVT_CLEAR, 32'h1, 4'hF);
        rchk(mvd_pkg::OFS_EVT_PENDING, 32'h2, "after clear bit 0");
        chk({63'h0, o_irq}, 64'h1, "irq while bit 1");
        u_drv.wr(mvd_pkg::OFS_EVT_CLEAR, 32'h2, 4'hF);
        chk({63'h0, o_irq}, 64'h0, "irq after clear");
        $display("test events done");
        // config bytes in little-endian lanes, device-side byte write
        u_drv.wr(mvd_pkg::OFS_CFG_SPACE, 32'h4433_2211, 4'hF);
        u_drv.wr(mvd_pkg::OFS_CFG_SPACE, 32'h0000_AA00, 4'h2);
        @(negedge i_mclk);
        i_dcfg_we = 1'b1;
        i_dcfg_addr = 12'h003;
        i_dcfg_data = 8'h77;
        @(negedge i_mclk);
        i_dcfg_we = 1'b0;
        rchk(mvd_pkg::OFS_CFG_SPACE, 32'h7733_AA11, "config word");
        rchk(mvd_pkg::OFS_CFG_GEN, g0 + 32'h2, "generation after byte");
        $display("test config done");
        // status flags, then a zero write resets the device
        u_drv.wr(mvd_pkg::OFS_DEV_STATUS, 32'h0F, 4'hF);
        rchk(mvd_pkg::OFS_DEV_STATUS, 32'h0F, "status");
        pulse_evt(1'b1, 1'b0);
        u_drv.wr(mvd_pkg::OFS_DEV_STATUS, 32'h0, 4'hF);
        chk({63'h0, o_dev_reset}, 64'h1, "soft reset pulse");
        rchk(mvd_pkg::OFS_EVT_PENDING, 32'h0, "pending after soft reset");
        chk({24'h0, o_queue_enable, o_dev_status}, 64'h0, "state after soft reset");
        $display("test status done");
        wrap_up();
    end
endmodule : tb_mvd_regs
